// *** src/uab_pkg.sv ***
// constants, types and register map of the auto-baud, wake and break serial block
// What this block does
// R1 - auto-baud enable starts calibration, receiver held busy
// R2 - counting starts at first rise after start
// R3 - remote sends sync character with five rises
// R4 - fifth rise: keep count, clear enable, flag
// R5 - 16-bit counter at one eighth base clock
// R6 - base clock: osc/64, osc/16 or osc/4
// R7 - counter starts at one, software subtracts one
// R8 - high byte written also in narrow modes
// R9 - with wake enabled, measure following character
// R10 - counter overflow sets overflow bit and flag
// R11 - keep counting after overflow, idle at fifth
// R12 - fifth rise sets flag again after read
// R13 - software clears overflow only after fifth rise
// R14 - wake on break only in asynchronous mode
// R15 - wake suppresses reception, falling edge wakes
// R16 - wake event sets flag, data read clears
// R17 - rise ending break clears wake enable
// R18 - nonzero character: first low time wakes
// R19 - remote sends long all-zero wake character
// R20 - software checks idle before enabling wake
// R21 - break: start, twelve zeros, stop, data ignored
// R22 - send break self-clears, next byte preloads
package uab_pkg;

   localparam logic [4:0]  OFS_CTRL      = 5'h00;
   localparam logic [4:0]  OFS_STAT      = 5'h04;
   localparam logic [4:0]  OFS_DIVL      = 5'h08;
   localparam logic [4:0]  OFS_DIVH      = 5'h0C;
   localparam logic [4:0]  OFS_RXD       = 5'h10;
   localparam logic [4:0]  OFS_TXD       = 5'h14;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   localparam int          PRE_W         = 6;
   localparam logic [5:0]  PRE_LAST_SLOW = 6'h3F;
   localparam logic [5:0]  PRE_LAST_MID  = 6'h0F;
   localparam logic [5:0]  PRE_LAST_FAST = 6'h03;

   localparam logic [15:0] DIV_RESET     = 16'h0000;
   localparam logic [15:0] DIV_START     = 16'h0001;
   localparam logic [15:0] DIV_STEP      = 16'h0001;
   localparam logic [15:0] DIV_MAX       = 16'hFFFF;
   localparam logic [2:0]  EDGE_FIRST    = 3'h1;
   localparam logic [2:0]  EDGE_LAST     = 3'h5;

   localparam logic [3:0]  BRK_BITS      = 4'hE;
   localparam logic [3:0]  CHAR_BITS     = 4'hA;
   localparam logic [3:0]  TX_LAST       = 4'h1;
   localparam logic [13:0] BRK_FRAME     = 14'h2000;
   localparam logic [4:0]  CHAR_PAD      = 5'h1F;
   localparam logic        LINE_IDLE     = 1'h1;

   typedef struct packed {
      logic sync_mode;
      logic transmit_enable;
      logic send_break;
      logic high_speed_select;
      logic wide_divider_select;
      logic wake_on_break_enable;
      logic auto_baud_enable;
   } uab_ctrl_t;

   typedef struct packed {
      logic tx_buf_full;
      logic tx_idle;
      logic receiver_idle_status;
      logic auto_baud_overflow;
      logic receive_flag;
   } uab_stat_t;

   localparam uab_ctrl_t   CTRL_RESET    = 7'h00;

   typedef enum logic [1:0] {
      AB_IDLE,
      AB_WAIT_START,
      AB_WAIT_RISE,
      AB_COUNT
   } uab_abd_state_t;

endpackage

// *** src/uab_baud_gen.sv ***
// prescaler making the base baud tick and the calibration tick
`timescale 1ns/10ps
module uab_baud_gen
#(
   parameter int SUB_W = 3
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic wide_divider_select,
   input  wire logic high_speed_select,
   output logic      base_tick,
   output logic      abd_tick
);

   logic [uab_pkg::PRE_W-1:0] pre;
   logic [uab_pkg::PRE_W-1:0] pre_last;
   logic [SUB_W-1:0]          sub;

   if (SUB_W < 1)
   begin : g_chk
      $error("SUB_W must be at least 1");
   end

   always_comb
   begin
      case ({wide_divider_select, high_speed_select})
         2'h0:    pre_last = uab_pkg::PRE_LAST_SLOW;   // see R6
         2'h3:    pre_last = uab_pkg::PRE_LAST_FAST;   // see R6
         default: pre_last = uab_pkg::PRE_LAST_MID;    // see R6
      endcase
   end

   // >= so a mode change to a shorter division never runs past the end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre       <= '0;
         base_tick <= 1'h0;
      end
      else
      begin
         pre       <= (pre >= pre_last) ? '0 : pre + 1'h1;
         base_tick <= (pre >= pre_last);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sub      <= '0;
         abd_tick <= 1'h0;
      end
      else
      begin
         if (base_tick)
            sub <= sub + 1'h1;
         abd_tick <= base_tick && (&sub);   // see R5
      end
   end

   AST_ABD_TICK_ON_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
      abd_tick |-> $past(base_tick)) else $error("calibration tick without base tick"); // see R5

endmodule

// *** src/uab_top.sv ***
// auto-baud, wake-on-break and break-send serial block with its axi4-lite slave
`timescale 1ns/10ps
module uab_top
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [4:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        rx_in,
   output logic             tx_out,
   output logic             receive_flag
);

   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   uab_pkg::uab_ctrl_t      ctrl;
   uab_pkg::uab_stat_t      stat;
   uab_pkg::uab_abd_state_t abd_state;

   logic [15:0] div;
   logic [15:0] tx_limit;
   logic [15:0] tx_cnt;
   logic [13:0] tx_shift;
   logic [3:0]  tx_left;
   logic [2:0]  abd_edges;
   logic [7:0]  buf_data;
   logic [31:0] rd_val;
   logic        auto_baud_overflow;
   logic        receiver_idle_status;
   logic        rx_meta;
   logic        rx_sync;
   logic        rx_prev;
   logic        rx_rise;
   logic        rx_fall;
   logic        base_tick;
   logic        abd_tick;
   logic        abd_done;
   logic        abd_ovf_set;
   logic        wake_set;
   logic        wake_clr;
   logic        wr_go;
   logic        wr_b0;
   logic        rd_go;
   logic        rx_read;
   logic        txd_wr;
   logic        tx_busy;
   logic        tx_is_brk;
   logic        tx_take;
   logic        bit_tick;
   logic        brk_done;
   logic        brk_armed;
   logic        buf_full;
   logic        buf_brk;

   function automatic logic is_mapped(input logic [4:0] a);
      is_mapped = (a == uab_pkg::OFS_CTRL) || (a == uab_pkg::OFS_STAT) ||
                  (a == uab_pkg::OFS_DIVL) || (a == uab_pkg::OFS_DIVH) ||
                  (a == uab_pkg::OFS_RXD)  || (a == uab_pkg::OFS_TXD);
   endfunction

   // bus slave: address and data are taken together, one write and one read open
   assign awready = awvalid && wvalid && !bvalid;
   assign wready  = awready;
   assign wr_go   = awready;
   assign wr_b0   = wr_go && wstrb[0];
   assign arready = !rvalid;
   assign rd_go   = arvalid && arready;
   assign rx_read = rd_go && (araddr == uab_pkg::OFS_RXD);
   assign txd_wr  = wr_b0 && (awaddr == uab_pkg::OFS_TXD);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'h0;
         bresp  <= uab_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid <= 1'h1;
         bresp  <= is_mapped(awaddr) ? uab_pkg::RESP_OKAY : uab_pkg::RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'h0;
   end

   assign stat.tx_buf_full          = buf_full;
   assign stat.tx_idle              = !tx_busy;
   assign stat.receiver_idle_status = receiver_idle_status;
   assign stat.auto_baud_overflow   = auto_baud_overflow;
   assign stat.receive_flag         = receive_flag;

   // received character data is not kept here, so the data register reads zero
   always_comb
   begin
      rd_val = '0;
      case (araddr)
         uab_pkg::OFS_CTRL: rd_val[$bits(ctrl)-1:0] = ctrl;
         uab_pkg::OFS_STAT: rd_val[$bits(stat)-1:0] = stat;
         uab_pkg::OFS_DIVL: rd_val[7:0] = div[7:0];
         uab_pkg::OFS_DIVH: rd_val[7:0] = div[15:8];
         default:           rd_val = '0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'h0;
         rdata  <= '0;
         rresp  <= uab_pkg::RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid <= 1'h1;
         rdata  <= rd_val;
         rresp  <= is_mapped(araddr) ? uab_pkg::RESP_OKAY : uab_pkg::RESP_SLVERR;
      end
      else if (rready)
         rvalid <= 1'h0;
   end

   // control bits; hardware clears come last so they win over a write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= uab_pkg::CTRL_RESET;
      else
      begin
         if (wr_b0 && (awaddr == uab_pkg::OFS_CTRL))
         begin
            ctrl <= uab_pkg::uab_ctrl_t'(wdata[$bits(ctrl)-1:0]);
            if (wdata[$bits(ctrl)-1])
               ctrl.wake_on_break_enable <= 1'h0;   // see R14
         end
         if (abd_done)
            ctrl.auto_baud_enable <= 1'h0;          // see R4
         if (wake_clr)
            ctrl.wake_on_break_enable <= 1'h0;      // see R17
         if (brk_done)
            ctrl.send_break <= 1'h0;                // see R22
      end
   end

   // receive line synchroniser; only rx_sync and later stages are looked at
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_meta <= uab_pkg::LINE_IDLE;
         rx_sync <= uab_pkg::LINE_IDLE;
         rx_prev <= uab_pkg::LINE_IDLE;
      end
      else
      begin
         rx_meta <= rx_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_rise  = rx_sync && !rx_prev;
   assign rx_fall  = !rx_sync && rx_prev;

   // wake watches edges only, so any low time counts, a short one included
   assign wake_set = ctrl.wake_on_break_enable && rx_fall;   // see R15, R18
   assign wake_clr = ctrl.wake_on_break_enable && rx_rise;   // see R17

   // held busy through calibration; also idle while wake is armed
   assign receiver_idle_status = (abd_state == uab_pkg::AB_IDLE);   // see R1, R11, R15

   assign abd_done    = (abd_state == uab_pkg::AB_COUNT) && rx_rise &&
                        (abd_edges == uab_pkg::EDGE_LAST - uab_pkg::EDGE_FIRST);
   assign abd_ovf_set = (abd_state == uab_pkg::AB_COUNT) && abd_tick && !abd_done &&
                        (div == uab_pkg::DIV_MAX);   // see R10

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         abd_state <= uab_pkg::AB_IDLE;
         abd_edges <= '0;
      end
      else if (!ctrl.auto_baud_enable)
         abd_state <= uab_pkg::AB_IDLE;
      else
      begin
         case (abd_state)
            uab_pkg::AB_IDLE:
               if (!ctrl.wake_on_break_enable && !ctrl.sync_mode)
                  abd_state <= uab_pkg::AB_WAIT_START;   // see R1, R9
            uab_pkg::AB_WAIT_START:
               if (rx_fall)
                  abd_state <= uab_pkg::AB_WAIT_RISE;
            uab_pkg::AB_WAIT_RISE:
               if (rx_rise)
               begin
                  abd_state <= uab_pkg::AB_COUNT;       // see R2
                  abd_edges <= uab_pkg::EDGE_FIRST;
               end
            uab_pkg::AB_COUNT:
               if (abd_done)
                  abd_state <= uab_pkg::AB_IDLE;        // see R4, R11
               else if (rx_rise)
                  abd_edges <= abd_edges + uab_pkg::EDGE_FIRST;
            default:
               abd_state <= uab_pkg::AB_IDLE;
         endcase
      end
   end

   // divider pair doubles as the calibration counter; software writes while counting are dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div <= uab_pkg::DIV_RESET;
      else if ((abd_state == uab_pkg::AB_WAIT_RISE) && rx_rise && ctrl.auto_baud_enable)
         div <= uab_pkg::DIV_START;                 // see R7
      else if ((abd_state == uab_pkg::AB_COUNT) && !abd_done)
      begin
         if (abd_tick)
            div <= div + uab_pkg::DIV_STEP;         // see R5, R8, R11
      end
      else if (wr_b0 && (awaddr == uab_pkg::OFS_DIVL))
         div[7:0] <= wdata[7:0];
      else if (wr_b0 && (awaddr == uab_pkg::OFS_DIVH))
         div[15:8] <= wdata[7:0];
   end

   // every set source beats the read that clears
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         receive_flag <= 1'h0;
      else if (abd_done || abd_ovf_set || wake_set)
         receive_flag <= 1'h1;                      // see R4, R10, R12, R16
      else if (rx_read)
         receive_flag <= 1'h0;
   end

   // overflow is cleared by writing one to its status bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         auto_baud_overflow <= 1'h0;
      else if (abd_ovf_set)
         auto_baud_overflow <= 1'h1;                // see R10
      else if (wr_b0 && (awaddr == uab_pkg::OFS_STAT) && wdata[1])
         auto_baud_overflow <= 1'h0;
   end

   // one-byte transmit buffer; a write while full is dropped
   assign brk_armed = (buf_full && buf_brk) || (tx_busy && tx_is_brk);
   assign tx_take   = !tx_busy && buf_full && ctrl.transmit_enable;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         buf_full <= 1'h0;
         buf_data <= '0;
         buf_brk  <= 1'h0;
      end
      else
      begin
         if (tx_take)
            buf_full <= 1'h0;
         if (txd_wr && !buf_full)
         begin
            buf_full <= 1'h1;                       // see R22
            buf_data <= wdata[7:0];
            buf_brk  <= ctrl.send_break && ctrl.transmit_enable && !brk_armed;   // see R21
         end
      end
   end

   // bit time is the divider plus one base ticks
   assign tx_limit = ctrl.wide_divider_select ? div : {8'h00, div[7:0]};
   assign bit_tick = tx_busy && base_tick && (tx_cnt == tx_limit);
   assign brk_done = bit_tick && tx_is_brk && (tx_left == uab_pkg::TX_LAST);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_busy   <= 1'h0;
         tx_is_brk <= 1'h0;
         tx_shift  <= '0;
         tx_left   <= '0;
         tx_cnt    <= '0;
         tx_out    <= uab_pkg::LINE_IDLE;
      end
      else if (!tx_busy)
      begin
         tx_cnt <= '0;
         tx_out <= uab_pkg::LINE_IDLE;
         if (tx_take)
         begin
            tx_busy   <= 1'h1;
            tx_is_brk <= buf_brk;
            if (buf_brk)
            begin
               tx_shift <= uab_pkg::BRK_FRAME;      // see R21
               tx_left  <= uab_pkg::BRK_BITS;
            end
            else
            begin
               tx_shift <= {uab_pkg::CHAR_PAD, buf_data, 1'h0};
               tx_left  <= uab_pkg::CHAR_BITS;
            end
         end
      end
      else
      begin
         tx_out <= tx_shift[0];
         if (base_tick)
            tx_cnt <= bit_tick ? '0 : tx_cnt + 16'h0001;
         if (bit_tick)
         begin
            tx_shift <= {uab_pkg::LINE_IDLE, tx_shift[13:1]};
            tx_left  <= tx_left - uab_pkg::TX_LAST;
            if (tx_left == uab_pkg::TX_LAST)
               tx_busy <= 1'h0;
         end
      end
   end

   uab_baud_gen #(
      .SUB_W (3)
   ) u_baud (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .wide_divider_select (ctrl.wide_divider_select),
      .high_speed_select   (ctrl.high_speed_select),
      .base_tick           (base_tick),
      .abd_tick            (abd_tick)
   );

   AST_ABD_NOT_IDLE: assert property (                                      // see R1
      ctrl.auto_baud_enable && !ctrl.wake_on_break_enable && !ctrl.sync_mode && !abd_done
      |=> !receiver_idle_status)
      else $error("receiver idle during calibration");

   AST_ABD_FIRST_COUNT: assert property (                                   // see R2
      (abd_state == uab_pkg::AB_WAIT_RISE) && rx_rise && ctrl.auto_baud_enable
      |=> (div == uab_pkg::DIV_START) && (abd_state == uab_pkg::AB_COUNT))
      else $error("counter did not start at one on first rise");

   AST_ABD_DONE: assert property (                                          // see R4
      abd_done |=> !ctrl.auto_baud_enable && receive_flag && receiver_idle_status
      && (div == $past(div)))
      else $error("fifth rise did not end calibration");

   AST_ABD_STEP: assert property (                                          // see R5
      (abd_state == uab_pkg::AB_COUNT) && abd_tick && !abd_done
      |=> div == $past(div) + uab_pkg::DIV_STEP)
      else $error("calibration counter did not step");

   AST_ABD_OVF: assert property (                                           // see R10
      abd_ovf_set |=> auto_baud_overflow && receive_flag && (div == uab_pkg::DIV_RESET)
      && (abd_state == uab_pkg::AB_COUNT))
      else $error("overflow not flagged or calibration stopped");

   AST_ABD_WAITS_WAKE: assert property (                                    // see R9
      ctrl.wake_on_break_enable && (abd_state == uab_pkg::AB_IDLE)
      |=> abd_state == uab_pkg::AB_IDLE)
      else $error("calibration began while wake armed");

   AST_WAKE_FLAG: assert property (                                         // see R16
      wake_set |=> receive_flag)
      else $error("wake event did not raise the flag");

   AST_WAKE_CLEAR: assert property (                                        // see R17
      wake_clr |=> !ctrl.wake_on_break_enable)
      else $error("rise did not clear wake enable");

   AST_WAKE_ASYNC_ONLY: assert property (                                   // see R14
      ctrl.sync_mode |-> !ctrl.wake_on_break_enable)
      else $error("wake armed in synchronous mode");

   AST_BRK_LOW: assert property (                                           // see R21
      tx_busy && tx_is_brk && (tx_left > uab_pkg::TX_LAST) |-> !tx_shift[0])
      else $error("break frame bit not low");

   AST_BRK_END: assert property (                                           // see R22
      brk_done |=> !ctrl.send_break && !tx_busy ##1 tx_out)
      else $error("send break not cleared after stop bit");

endmodule

// *** testbench/uab_node_model.sv ***
// remote serial node: sends frames and breaks, decodes the block's transmit pin
`timescale 1ns/10ps
module uab_node_model
#(
   parameter int RX_BT = 16
)
(
   input  wire logic clk,
   input  wire logic tx_line,
   output logic      rx_line
);
   logic [7:0] rx_byte;
   int         n_rx;
   int         brk_len;
   int         n;

   initial
   begin
      rx_line = 1'b1;
      rx_byte = 8'h00;
      n_rx    = 0;
      brk_len = 0;
   end

   task automatic drive(input logic lv, input int cyc);
      rx_line <= lv;
      repeat (cyc) @(posedge clk);
   endtask

   // lsb first, one start and one stop bit
   task automatic send_frame(input logic [7:0] d, input int bt);
      drive(1'b0, bt);
      for (int i = 0; i < 8; i++)
         drive(d[i], bt);
      drive(1'b1, bt);
   endtask

   // all-zero wake character of thirteen bit times
   task automatic send_break(input int bt);
      drive(1'b0, 13 * bt);
      drive(1'b1, bt);
   endtask

   // a low run beyond twelve bits is a break, else sample mid-bit
   always
   begin
      @(negedge tx_line);
      n = 0;
      while (tx_line === 1'b0 && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
      if (n > 12 * RX_BT)
         brk_len = n;
      else
      begin
         repeat (RX_BT / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            rx_byte[i] = tx_line;
            repeat (RX_BT) @(posedge clk);
         end
         n_rx++;
      end
   end
endmodule

// *** testbench/uart_autobaud_wake_break_test.sv ***
// self-checking bench for the auto-baud, wake and break serial block
`timescale 1ns/10ps
module uart_autobaud_wake_break_test;
   logic        aclk;
   logic        aresetn;
   logic [4:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [4:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        rx_in;
   logic        tx_out;
   logic        receive_flag;
   logic [31:0] rd_data;
   logic [1:0]  rd_resp;
   logic [15:0] cnt;
   int          n_fail;
   int          checks_done;
   int          dv;

   uab_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .rx_in, .tx_out, .receive_flag);

   uab_node_model #(.RX_BT(16)) link (.clk(aclk), .tx_line(tx_out), .rx_line(rx_in));

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // free-running prescalers leave the phase open, hence a tolerance
   task automatic near(input string what, input int exp, input int got, input int tol);
      checks_done++;
      if (got < exp - tol || got > exp + tol)
      begin
         n_fail++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // 0 awready, 1 bvalid, 2 arready, 3 rvalid; judged at the falling edge
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
      end
      while ((k == 0 ? awready : k == 1 ? bvalid : k == 2 ? arready : rvalid) !== 1'b1
             && n < 100);
      if (n >= 100)
      begin
         n_fail++;
         $display("Error handshake %0d expected 1 seen 0", k);
         close_out();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      wait_hi(0);
      chk("wready", 32'h1, {31'h0, wready});
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      wait_hi(1);
      chk("bresp", 32'h0, {30'h0, bresp});
      @(posedge aclk);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [4:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      wait_hi(2);
      @(posedge aclk);
      arvalid <= 1'b0;
      wait_hi(3);
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd_div();
      rd(uab_pkg::OFS_DIVH);
      chk("divider high byte", 32'h0, rd_data);
      rd(uab_pkg::OFS_DIVL);
      cnt = {rd_data[15:8], rd_data[7:0]};
   endtask

   initial
   begin
      repeat (60000) @(posedge aclk);
      n_fail++;
      $display("Error run length expected done seen hang");
      close_out();
   end

   initial
   begin
      aresetn = 1'b0;
      awaddr = 5'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 5'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      n_fail = 0;
      checks_done = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(5'h18);
      chk("unmapped resp", 32'h2, {30'h0, rd_resp});
      wstrb <= 4'h0;
      wr(uab_pkg::OFS_CTRL, 32'h1);
      wstrb <= 4'hF;
      rd(uab_pkg::OFS_CTRL);
      chk("ctrl masked write", 32'h0, rd_data);
      wr(uab_pkg::OFS_CTRL, 32'h42);
      rd(uab_pkg::OFS_CTRL);
      chk("wake refused in sync mode", 32'h40, rd_data);
      // every divider select pair, sync at 256 cycles a bit
      for (int m = 0; m < 4; m++)
      begin
         dv = m == 0 ? 512 : m == 3 ? 32 : 128;
         wr(uab_pkg::OFS_CTRL, {28'h0, m[1:0], 2'h1});
         rd(uab_pkg::OFS_STAT);
         chk("idle in calibration", 32'h0, rd_data & 32'h4);
         link.send_frame(8'h55, 256);
         repeat (10) @(posedge aclk);
         rd(uab_pkg::OFS_STAT);
         chk("stat after sync", 32'h5, rd_data & 32'h7);
         rd_div();
         near("count", 2048 / dv + 1, int'(cnt), 1);
         rd(uab_pkg::OFS_CTRL);
         chk("enable cleared", {28'h0, m[1:0], 2'h0}, rd_data);
         rd(uab_pkg::OFS_RXD);
         rd(uab_pkg::OFS_STAT);
         chk("flag cleared", 32'h0, rd_data & 32'h1);
      end
      // wake and auto-baud together: the break must not be measured
      rd(uab_pkg::OFS_STAT);
      chk("idle before wake", 32'h4, rd_data & 32'h4);
      wr(uab_pkg::OFS_CTRL, 32'h7);
      fork
         link.send_break(256);
         begin
            repeat (100) @(posedge aclk);
            @(negedge aclk);
            chk("wake flag pin", 32'h1, {31'h0, receive_flag});
            @(posedge aclk);
            rd(uab_pkg::OFS_CTRL);
            chk("wake held in break", 32'h7, rd_data);
            rd(uab_pkg::OFS_RXD);
            rd(uab_pkg::OFS_STAT);
            chk("wake flag read", 32'h0, rd_data & 32'h1);
         end
      join
      rd(uab_pkg::OFS_CTRL);
      chk("wake cleared by rise", 32'h5, rd_data);
      link.send_frame(8'h55, 256);
      repeat (10) @(posedge aclk);
      rd_div();
      near("count after break", 17, int'(cnt), 1);
      rd(uab_pkg::OFS_RXD);
      wr(uab_pkg::OFS_STAT, 32'h2);
      rd(uab_pkg::OFS_STAT);
      chk("overflow clear", 32'h4, rd_data & 32'h7);
      // break of 13 low bits at 16 cycles a bit, sync preloaded behind it
      wr(uab_pkg::OFS_DIVL, 32'h3);
      wr(uab_pkg::OFS_CTRL, 32'h3C);
      wr(uab_pkg::OFS_TXD, 32'hA5);
      repeat (5) @(posedge aclk);
      wr(uab_pkg::OFS_TXD, 32'h55);
      rd(uab_pkg::OFS_STAT);
      chk("byte held during break", 32'h10, rd_data & 32'h18);
      repeat (700) @(posedge aclk);
      near("break low time", 208, link.brk_len, 4);
      chk("byte after break", 32'h55, {24'h0, link.rx_byte});
      chk("bytes after break", 32'h1, link.n_rx);
      rd(uab_pkg::OFS_CTRL);
      chk("send break cleared", 32'h2C, rd_data);
      rd(uab_pkg::OFS_STAT);
      chk("transmitter drained", 32'h08, rd_data & 32'h18);
      close_out();
   end
endmodule
